// >>> src/bcts_pkg.sv
package bcts_pkg;

  // Operand widths
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned BIT_W  = 3;
  localparam int unsigned DATA_W = 8;

  // Largest legal operands
  localparam logic [6:0] ADDR_MAX = 7'h7F;
  localparam logic [2:0] BIT_MAX  = 3'h7;

  // Seed of the one-hot bit mask
  localparam logic [7:0] BIT_ONE  = 8'h01;

  // Operations handed over by the decoder
  typedef enum logic [1:0] {
    BCTS_OP_NONE,
    BCTS_OP_CLEAR,
    BCTS_OP_SKIP_CLR,
    BCTS_OP_SKIP_SET
  } bcts_op_t;

  // One decoded instruction
  typedef struct packed {
    bcts_op_t    op;
    logic [6:0]  addr;
    logic [2:0]  bitIdx;
  } bcts_instr_t;

  // Write-back to the register file
  typedef struct packed {
    logic        en;
    logic [6:0]  addr;
    logic [7:0]  data;
  } bcts_wr_t;

  // Execution state
  typedef enum logic {
    BCTS_EXEC,
    BCTS_SKIP
  } bcts_phase_t;

  typedef struct packed {
    bcts_phase_t phase;
    bcts_wr_t    wr;
    logic        skipNext;
  } bcts_state_t;

  localparam bcts_wr_t WR_RESET = '{en: 1'b0, addr: 7'h00, data: 8'h00};

endpackage

// >>> src/bit_clear_and_test_skip.sv
// Operation
// - A bit-clear writes zero into bit b of register f and keeps the other bits.
// - A test-skip-if-clear lets the next instruction run when the tested bit is one.
// - A test-skip-if-clear with the tested bit zero replaces the next instruction by a no-op, taking two cycles.
// - A test-skip-if-set skips the next instruction when the tested bit is one.
`timescale 1ns/10ps
module bit_clear_and_test_skip (
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 reset_n,
  // Decoded instruction
  input  wire logic                 instrValid,
  input  wire bcts_pkg::bcts_instr_t instr,
  // Register-file read port (combinational read of instr.addr)
  output logic [6:0]                rdAddr,
  input  wire logic [7:0]           rdData,
  // Register-file write port
  output bcts_pkg::bcts_wr_t        wr,
  // Fetch-stage control
  output logic                      squash,
  output logic                      skipTaken,
  // Status flags write enable
  output logic                      statusWrEn
);

  bcts_pkg::bcts_state_t state;
  bcts_pkg::bcts_state_t next_state;
  logic                  tested;
  logic [7:0]            clearMask;

  // Read address follows the operand; bit index picks the tested bit
  assign rdAddr    = instr.addr;
  assign tested    = rdData[instr.bitIdx];
  // Mask is built from the 8-bit seed BIT_ONE, so no wider shifter result can leak in
  assign clearMask = ~(bcts_pkg::BIT_ONE << instr.bitIdx);

  // Squash is combinational so fetch drops the slot in the skip cycle
  assign squash     = (state.phase == bcts_pkg::BCTS_SKIP);
  assign skipTaken  = state.skipNext;
  assign wr         = state.wr;
  assign statusWrEn = 1'b0;

  // Next-state logic
  always_comb begin
    next_state          = state;
    next_state.wr       = bcts_pkg::WR_RESET;
    next_state.skipNext = 1'b0;
    next_state.phase    = bcts_pkg::BCTS_EXEC;
    unique case (state.phase)
      bcts_pkg::BCTS_EXEC: begin
        if (instrValid) begin
          unique case (instr.op)
            bcts_pkg::BCTS_OP_CLEAR: begin
              next_state.wr.en   = 1'b1;
              next_state.wr.addr = instr.addr;
              next_state.wr.data = rdData & clearMask;
            end
            bcts_pkg::BCTS_OP_SKIP_CLR: begin
              if (!tested) begin
                next_state.phase    = bcts_pkg::BCTS_SKIP;
                next_state.skipNext = 1'b1;
              end
            end
            bcts_pkg::BCTS_OP_SKIP_SET: begin
              if (tested) begin
                next_state.phase    = bcts_pkg::BCTS_SKIP;
                next_state.skipNext = 1'b1;
              end
            end
            bcts_pkg::BCTS_OP_NONE: begin
              next_state.phase = bcts_pkg::BCTS_EXEC;
            end
          endcase
        end
      end
      // Discarded slot executes as a no-op; input ignored
      bcts_pkg::BCTS_SKIP: begin
        next_state.phase = bcts_pkg::BCTS_EXEC;
      end
    endcase
  end

  // State register
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state.phase    <= bcts_pkg::BCTS_EXEC;
      state.wr       <= bcts_pkg::WR_RESET;
      state.skipNext <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // Checks
  // Qualifiers mirror the taking rule: a slot offered while squash is high
  // is the discarded instruction and must leave no trace.
  logic takeAny;
  logic takeClear;
  logic takeSkipClr;
  logic takeSkipSet;
  logic takeNone;
  logic skipNow;

  // Checker qualifiers only; no state behind them
  assign takeAny     = instrValid && !squash;
  assign takeClear   = takeAny && (instr.op == bcts_pkg::BCTS_OP_CLEAR);
  assign takeSkipClr = takeAny && (instr.op == bcts_pkg::BCTS_OP_SKIP_CLR);
  assign takeSkipSet = takeAny && (instr.op == bcts_pkg::BCTS_OP_SKIP_SET);
  assign takeNone    = takeAny && (instr.op == bcts_pkg::BCTS_OP_NONE);
  assign skipNow     = (takeSkipClr && !tested) || (takeSkipSet && tested);

  a_clear_bit_zero: assert property (@(posedge clock) disable iff (!reset_n)
    instrValid && !squash && instr.op == bcts_pkg::BCTS_OP_CLEAR |=> wr.en && wr.data[$past(instr.bitIdx)] == 1'b0)
    else $error("cleared bit not zero");

  a_clear_others_kept: assert property (@(posedge clock) disable iff (!reset_n)
    instrValid && !squash && instr.op == bcts_pkg::BCTS_OP_CLEAR |=> (wr.data | (bcts_pkg::BIT_ONE << $past(instr.bitIdx)))
      == ($past(rdData) | (bcts_pkg::BIT_ONE << $past(instr.bitIdx))))
    else $error("other bits changed");

  a_skipclr_no_skip: assert property (@(posedge clock) disable iff (!reset_n)
    instrValid && !squash && instr.op == bcts_pkg::BCTS_OP_SKIP_CLR && tested |=> !squash)
    else $error("skipped with bit set");

  a_skipclr_two_cycle: assert property (@(posedge clock) disable iff (!reset_n)
    instrValid && !squash && instr.op == bcts_pkg::BCTS_OP_SKIP_CLR && !tested |=> squash ##1 !squash)
    else $error("skip not one slot");

  a_skipset_skip: assert property (@(posedge clock) disable iff (!reset_n)
    instrValid && !squash && instr.op == bcts_pkg::BCTS_OP_SKIP_SET |=> squash == $past(tested))
    else $error("skip-if-set wrong");

  a_clear_addr_kept: assert property (@(posedge clock) disable iff (!reset_n)
    instrValid && !squash && instr.op == bcts_pkg::BCTS_OP_CLEAR |=> wr.addr == $past(instr.addr))
    else $error("write address wrong");

  a_flags_untouched: assert property (@(posedge clock) disable iff (!reset_n)
    !statusWrEn)
    else $error("status flags written");

  a_skip_no_write: assert property (@(posedge clock) disable iff (!reset_n)
    squash |=> !wr.en)
    else $error("write during skipped slot");

  a_clear_no_skip: assert property (@(posedge clock) disable iff (!reset_n)
    takeClear |=> !squash && !skipTaken)
    else $error("clear caused a skip");

  a_clear_data_value: assert property (@(posedge clock) disable iff (!reset_n)
    takeClear |=> wr.data == ($past(rdData) & ~(bcts_pkg::BIT_ONE << $past(instr.bitIdx))))
    else $error("clear data wrong");

  a_skipclr_no_write: assert property (@(posedge clock) disable iff (!reset_n)
    takeSkipClr |=> !wr.en)
    else $error("skip-if-clear wrote");

  a_skipclr_runs_on: assert property (@(posedge clock) disable iff (!reset_n)
    takeSkipClr && tested |=> !skipTaken)
    else $error("skip flag with bit set");

  a_skip_flag_match: assert property (@(posedge clock) disable iff (!reset_n)
    skipTaken == squash)
    else $error("skip flag and squash differ");

  a_skipped_ignored: assert property (@(posedge clock) disable iff (!reset_n)
    squash |=> !squash)
    else $error("skipped slot started a skip");

  a_skip_cause: assert property (@(posedge clock) disable iff (!reset_n)
    squash |-> $past(skipNow))
    else $error("skip without a taken test");

  a_skipset_no_write: assert property (@(posedge clock) disable iff (!reset_n)
    takeSkipSet |=> !wr.en)
    else $error("skip-if-set wrote");

  a_skipset_two_cycle: assert property (@(posedge clock) disable iff (!reset_n)
    takeSkipSet && tested |=> squash ##1 !squash)
    else $error("skip-if-set not one slot");

  a_none_quiet: assert property (@(posedge clock) disable iff (!reset_n)
    takeNone |=> !wr.en && !squash)
    else $error("empty op acted");

  a_idle_quiet: assert property (@(posedge clock) disable iff (!reset_n)
    !takeAny |=> !wr.en)
    else $error("write without a taken clear");

  // Main scenarios, back-to-back clears included
  c_clear: cover property (@(posedge clock) disable iff (!reset_n) wr.en);
  c_back_to_back: cover property (@(posedge clock) disable iff (!reset_n)
    takeClear ##1 takeClear);
  c_skip_clr: cover property (@(posedge clock) disable iff (!reset_n)
    instrValid && instr.op == bcts_pkg::BCTS_OP_SKIP_CLR && !tested ##1 squash);
  c_skip_set: cover property (@(posedge clock) disable iff (!reset_n)
    instrValid && instr.op == bcts_pkg::BCTS_OP_SKIP_SET && tested ##1 squash);
  c_no_skip: cover property (@(posedge clock) disable iff (!reset_n)
    instrValid && !squash && instr.op == bcts_pkg::BCTS_OP_SKIP_CLR && tested);

endmodule

// >>> dv/bcts_regfile_model.sv
`timescale 1ns/10ps
module bcts_regfile_model (
  // Clock
  input  wire logic               clock,
  // Read and write ports
  input  wire logic [6:0]         rdAddr,
  output logic [7:0]              rdData,
  input  wire bcts_pkg::bcts_wr_t wr
);
  logic [7:0] mem [128];
  // All ones at start, so a first skip-if-set always skips
  initial for (int i = 0; i < 128; i++) mem[i] = 8'hFF;
  // Pending write forwarded, else back-to-back reads go stale
  assign rdData = (wr.en && wr.addr == rdAddr) ? wr.data : mem[rdAddr];
  // Write-back lands on the rising edge
  always @(posedge clock) begin
    if (wr.en) mem[wr.addr] <= wr.data;
  end
endmodule

// >>> dv/bit_clear_and_test_skip_bench.sv
`timescale 1ns/10ps
module bit_clear_and_test_skip_bench;
  logic                  clock, reset_n, instrValid, squash, skipTaken, statusWrEn;
  logic [6:0]            rdAddr;
  logic [7:0]            rdData;
  bcts_pkg::bcts_instr_t instr;
  bcts_pkg::bcts_wr_t    wr;
  logic [7:0]            sh [128];
  int                    bad_count, checks_done;
  // Free-running clock
  initial begin
    clock = 1'h0;
    forever #4 clock = ~clock;
  end
  bit_clear_and_test_skip uut (.clock(clock), .reset_n(reset_n), .instrValid(instrValid), .instr(instr),
    .rdAddr(rdAddr), .rdData(rdData), .wr(wr), .squash(squash), .skipTaken(skipTaken), .statusWrEn(statusWrEn));
  bcts_regfile_model rf (.clock(clock), .rdAddr(rdAddr), .rdData(rdData), .wr(wr));
  // Compare and count
  task check(input logic [15:0] seen, input logic [15:0] want);
    checks_done++;
    if (seen !== want) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task give_verdict;
    if (bad_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // One instruction, then a clear of the same bit right behind it
  task run(input bcts_pkg::bcts_op_t op, input logic [6:0] a, input logic [2:0] b);
    logic       sq;
    logic [7:0] m;
    m = 8'h01 << b;
    sq = (op == bcts_pkg::BCTS_OP_SKIP_CLR) ? ~|(sh[a] & m) : (op == bcts_pkg::BCTS_OP_SKIP_SET) && |(sh[a] & m);
    @(posedge clock);
    instrValid <= 1'h1;
    instr <= '{op, a, b};
    @(posedge clock);
    instr <= '{bcts_pkg::BCTS_OP_CLEAR, a, b};
    #1;
    check(squash, sq);
    check(skipTaken, sq);
    check(statusWrEn, 1'h0);
    check(rdAddr, a);
    if (op == bcts_pkg::BCTS_OP_CLEAR) begin
      check(wr, {1'h1, a, sh[a] & ~m});
      sh[a] = sh[a] & ~m;
    end else check(wr, 16'h0000);
    @(posedge clock);
    instrValid <= 1'h0;
    #1;
    // Squashed follower must leave the write port quiet
    check(wr, sq ? 16'h0000 : {1'h1, a, sh[a] & ~m});
    if (!sq) sh[a] = sh[a] & ~m;
  endtask
  // Every bit index, extreme addresses
  task clear_sweep;
    for (int i = 0; i < 8; i++) run(bcts_pkg::BCTS_OP_CLEAR, {i[2:0], 4'hF}, i[2:0]);
    run(bcts_pkg::BCTS_OP_CLEAR, 7'h00, 3'h0);
  endtask
  // First pass runs on, follower clears, second pass skips
  task skip_clear;
    run(bcts_pkg::BCTS_OP_SKIP_CLR, 7'h40, 3'h5);
    run(bcts_pkg::BCTS_OP_SKIP_CLR, 7'h40, 3'h5);
  endtask
  task skip_set;
    run(bcts_pkg::BCTS_OP_SKIP_SET, 7'h41, 3'h5);
    run(bcts_pkg::BCTS_OP_SKIP_SET, 7'h40, 3'h5);
    run(bcts_pkg::BCTS_OP_NONE, 7'h42, 3'h1);
  endtask
  // Main sequence
  initial begin
    reset_n = 1'h0;
    instrValid = 1'h0;
    instr = '0;
    for (int i = 0; i < 128; i++) sh[i] = 8'hFF;
    repeat (20) @(posedge clock);
    reset_n <= 1'h1;
    clear_sweep();
    skip_clear();
    skip_set();
    give_verdict();
  end
  // About 60 cycles expected; cut a hang well beyond
  initial begin
    repeat (1000) @(posedge clock);
    bad_count++;
    give_verdict();
  end
endmodule
